// ===== pkg/tccr_consts.svh
// Purpose: register offsets, field positions and reset values of the touch configuration bank
// Assumes: byte-wide register port, 8-bit addresses
// Notes:   16-bit quantities are split into upper and lower byte registers
`ifndef TCCR_CONSTS_SVH
`define TCCR_CONSTS_SVH

`define TCCR_HRES_UP      8'h00
`define TCCR_HRES_LO      8'h01
`define TCCR_VRES_UP      8'h02
`define TCCR_VRES_LO      8'h03
`define TCCR_SLIDE_STEPS  8'h04
`define TCCR_CAL_BASE     8'h05
`define TCCR_CAL_LAST     8'h14
`define TCCR_CAP_CFG      8'h15
`define TCCR_TRK_RATE     8'h16
`define TCCR_RESP_TIME    8'h17
`define TCCR_STUCK_TOUT   8'h18
`define TCCR_LP_SEL       8'h19
`define TCCR_STATUS2      8'h1A

`define TCCR_CAL_BYTES    16
`define TCCR_CAL_ALL      16'hFFFF
`define TCCR_CFG_TRK_BIT  5
`define TCCR_CFG_STK_BIT  4
`define TCCR_CFG_LPW_BIT  2
`define TCCR_CFG_MASK     8'h34
`define TCCR_RES_UP_MASK  8'h3F
`define TCCR_RESP_MASK    8'h3F
`define TCCR_LP_SEL_MASK  8'h03
`define TCCR_ST2_CAL_BIT  0
`define TCCR_DEB_MAX      6'h20
`define TCCR_DEB_MIN      6'h01
`define TCCR_BYTE_RST     8'h00
`define TCCR_RES_RST      14'h0000
`define TCCR_ELECTRODES   4

`endif

// ===== pkg/tccr_pkg.sv
// Purpose: shared types of the touch configuration bank
// Assumes: constants come from tccr_consts.svh
// Notes:   coordinates are truncated to 16 bits
package tccr_pkg;
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
    } tccr_coord_t;

    typedef struct packed {
        logic [13:0] horiz;
        logic [13:0] vert;
    } tccr_res_t;
endpackage : tccr_pkg

// ===== verif/tb_touch_config_calibration_regs.sv
// Purpose: self-checking bench of the touch configuration bank
// Assumes: offsets from tccr_consts.svh, host model drives the register port
// Notes:   random calibration data and samples come from a fixed seed
`timescale 1ns/1ps
`include "tccr_consts.svh"

module tb_touch_config_calibration_regs import tccr_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clk_en = 1'b1;
    logic        sample_valid = 1'b0;
    logic        cap_sample_tick = 1'b0;
    logic [15:0] raw_x = 16'h0000;
    logic [15:0] raw_y = 16'h0000;
    logic [3:0]  elec_raw_touch = 4'h0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, rdv, slide_step_count;
    logic        reg_wr, reg_rd, coord_valid, uncalibrated, run_scan_enable;
    tccr_coord_t coord;
    tccr_res_t   resolution;
    logic [15:0] two_touch_const_x, two_touch_const_y;
    logic [3:0]  elec_touched, baseline_update, shutdown_scan_mask;
    logic [7:0]  cal [16];
    logic [13:0] h, v;
    int          err_count = 0;
    int          checks_done = 0;
    int          bu_cnt = 0;
    int          bu_mark = 0;

    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) bu_cnt <= bu_cnt + $countones(baseline_update);

    // clock enable dropped once to show that a write is frozen out
    tccr_regs tccr_regs_i (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .raw_x(raw_x), .raw_y(raw_y), .coord(coord), .coord_valid(coord_valid),
        .resolution(resolution), .slide_step_count(slide_step_count), .two_touch_const_x(two_touch_const_x),
        .two_touch_const_y(two_touch_const_y), .uncalibrated(uncalibrated), .cap_sample_tick(cap_sample_tick),
        .elec_raw_touch(elec_raw_touch), .elec_touched(elec_touched), .baseline_update(baseline_update),
        .run_scan_enable(run_scan_enable), .shutdown_scan_mask(shutdown_scan_mask));
    tccr_host tccr_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    function automatic logic [15:0] coef(input int k);
        return {cal[2*k], cal[2*k+1]};
    endfunction : coef

    // low 16 bits of the sum are the same whether coefficients are signed or not
    function automatic logic [15:0] lin(input int k, input logic [15:0] rx, input logic [15:0] ry);
        return coef(k) * rx + coef(k + 1) * ry + coef(k + 2);
    endfunction : lin

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tccr_host_i.wr(a, d);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] e);
        tccr_host_i.rd(a, rdv);
        chk(what, e, rdv);
    endtask : rdc

    task automatic st();
        @(posedge ref_clk);
        #1;
    endtask : st

    // snapshot off the edge so the counter's own update never races it
    task automatic mark();
        #1 bu_mark = bu_cnt;
    endtask : mark

    task automatic tk(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            cap_sample_tick <= 1'b1;
            @(posedge ref_clk);
            cap_sample_tick <= 1'b0;
        end
        st();
    endtask : tk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up

    initial begin
        repeat (5000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'h1D4B));
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        st();
        chk("uncal", 1, uncalibrated);
        chk("run scan", 1, run_scan_enable);
        rdc("status", `TCCR_STATUS2, 8'h01);
        rdc("unmapped", 8'h80, 8'h00);
        h = 14'($urandom);
        v = 14'($urandom);
        wr(`TCCR_HRES_UP, {2'b11, h[13:8]});
        wr(`TCCR_HRES_LO, h[7:0]);
        st();
        chk("res pending", 0, resolution);
        wr(`TCCR_VRES_UP, {2'b11, v[13:8]});
        wr(`TCCR_VRES_LO, v[7:0]);
        st();
        // the first vertical byte completes the pair; the later low byte waits for a horizontal write
        chk("res first", {h, v[13:8], 8'h00}, resolution);
        wr(`TCCR_HRES_LO, h[7:0]);
        st();
        chk("res", {h, v}, resolution);
        rdc("hres up", `TCCR_HRES_UP, {2'b00, h[13:8]});
        foreach (cal[i]) begin
            if (i == 15) chk("cal partial", 1, uncalibrated);
            cal[i] = 8'($urandom);
            wr(`TCCR_CAL_BASE + 8'(i), cal[i]);
        end
        st();
        chk("cal done", 0, uncalibrated);
        chk("consts", {coef(6), coef(7)}, {two_touch_const_x, two_touch_const_y});
        for (int n = 0; n < 4; n++) begin
            @(posedge ref_clk);
            raw_x <= (n == 0) ? 16'hFFFF : 16'($urandom);
            raw_y <= (n == 0) ? 16'hFFFF : 16'($urandom);
            sample_valid <= 1'b1;
            @(posedge ref_clk);
            sample_valid <= 1'b0;
            #1 chk("coord valid", 1, coord_valid);
            chk("coord", {lin(0, raw_x, raw_y), lin(3, raw_x, raw_y)}, coord);
        end
        wr(`TCCR_SLIDE_STEPS, 8'hA5);
        st();
        chk("slide", 8'hA5, slide_step_count);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(`TCCR_SLIDE_STEPS, 8'h5A);
        st();
        chk("frozen", 8'hA5, slide_step_count);
        clk_en <= 1'b1;
        wr(`TCCR_VRES_LO, 8'h00);
        st();
        chk("invalidate", 1, uncalibrated);
        chk("res held", {h, v}, resolution);
        wr(`TCCR_RESP_TIME, 8'hC3);
        rdc("resp", `TCCR_RESP_TIME, 8'h03);
        elec_raw_touch <= 4'h5;
        tk(2);
        chk("debounce early", 0, elec_touched);
        tk(1);
        chk("debounce", 5, elec_touched);
        wr(`TCCR_STUCK_TOUT, 8'h02);
        wr(`TCCR_CAP_CFG, 8'h10);
        mark();
        tk(1);
        chk("stuck early", 5, elec_touched);
        tk(1);
        chk("stuck", 0, elec_touched);
        chk("stuck rebase", 2, bu_cnt - bu_mark);
        elec_raw_touch <= 4'h0;
        wr(`TCCR_CAP_CFG, 8'h20);
        wr(`TCCR_TRK_RATE, 8'h03);
        mark();
        // six ticks hold exactly two intervals of three whatever the phase
        tk(6);
        chk("tracker", 8, bu_cnt - bu_mark);
        wr(`TCCR_TRK_RATE, 8'h00);
        mark();
        tk(3);
        chk("tracker off", 0, bu_cnt - bu_mark);
        wr(`TCCR_TRK_RATE, 8'h01);
        wr(`TCCR_CAP_CFG, 8'hFF);
        rdc("cfg", `TCCR_CAP_CFG, 8'h34);
        mark();
        tk(2);
        chk("run scan off", 0, run_scan_enable);
        chk("no scan", 0, bu_cnt - bu_mark);
        for (int s = 0; s < 4; s++) begin
            wr(`TCCR_LP_SEL, 8'(s) | 8'hFC);
            st();
            chk("wake select", 4'h1 << s, shutdown_scan_mask);
        end
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        st();
        chk("reset mask", 0, shutdown_scan_mask);
        rdc("cfg reset", `TCCR_CAP_CFG, 8'h00);
        wrap_up();
    end
endmodule : tb_touch_config_calibration_regs

// ===== verif/tccr_host.sv
// Purpose: host side of the register port, one access at a time
// Assumes: strobes last one cycle, read data sampled the cycle after
// Notes:   released address and data lines show inverted values
`timescale 1ns/1ps

module tccr_host (
    input  wire logic       ref_clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd
endmodule : tccr_host

// ===== verilog/tccr_regs.sv
// Purpose: touch controller configuration and calibration register bank
// Assumes: one clock, raw samples and touch levels come from same-clock logic
// Notes:   byte-wide register port, read data one cycle after the read strobe
`timescale 1ns/1ps
`include "tccr_consts.svh"

module tccr_regs
    import tccr_pkg::*;
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 clk_en,
    // register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // resistive samples
    input  wire logic                 sample_valid,
    input  wire logic [15:0]          raw_x,
    input  wire logic [15:0]          raw_y,
    output tccr_coord_t               coord,
    output logic                      coord_valid,
    // configuration to the gesture engine
    output tccr_res_t                 resolution,
    output logic      [7:0]           slide_step_count,
    output logic      [15:0]          two_touch_const_x,
    output logic      [15:0]          two_touch_const_y,
    output logic                      uncalibrated,
    // capacitive sensing
    input  wire logic                 cap_sample_tick,
    input  wire logic [3:0]           elec_raw_touch,
    output logic      [3:0]           elec_touched,
    output logic      [3:0]           baseline_update,
    output logic                      run_scan_enable,
    output logic      [3:0]           shutdown_scan_mask
);

    logic [7:0]  hres_up_q, hres_lo_q, vres_up_q, vres_lo_q;
    logic        hres_wr_q, vres_wr_q;
    tccr_res_t   res_q;
    logic [7:0]  slide_q;
    logic [7:0]  cal_q [`TCCR_CAL_BYTES];
    logic [15:0] cal_seen_q;
    logic        uncal_q;
    logic [7:0]  cfg_q, trk_rate_q, resp_q, stuck_tout_q, lp_sel_q;
    logic [7:0]  rdata_q;
    tccr_coord_t coord_q;
    logic        coord_valid_q;
    logic [7:0]  trk_cnt_q;
    logic        run_scan_q;
    logic [3:0]  lp_mask_q;

    logic        wr_hres, wr_vres, wr_cal, res_commit, cal_done;
    logic [3:0]  cal_idx;
    logic [3:0]  cal_idx_rd;
    logic        trk_en, stk_en, lpw_en, scan_tick, trk_hit;
    logic [5:0]  deb_n;

    assign wr_hres = reg_wr && (reg_addr == `TCCR_HRES_UP || reg_addr == `TCCR_HRES_LO);
    assign wr_vres = reg_wr && (reg_addr == `TCCR_VRES_UP || reg_addr == `TCCR_VRES_LO);
    assign wr_cal  = reg_wr && reg_addr >= `TCCR_CAL_BASE && reg_addr <= `TCCR_CAL_LAST;
    assign cal_idx = 4'(reg_addr - `TCCR_CAL_BASE);
    assign cal_idx_rd = 4'(reg_addr - `TCCR_CAL_BASE);
    assign trk_en  = cfg_q[`TCCR_CFG_TRK_BIT];
    assign stk_en  = cfg_q[`TCCR_CFG_STK_BIT];
    assign lpw_en  = cfg_q[`TCCR_CFG_LPW_BIT];
    // both axes written since the last commit, this write included
    assign res_commit = (hres_wr_q || wr_hres) && (vres_wr_q || wr_vres);
    assign cal_done   = (cal_seen_q | (wr_cal ? (16'h0001 << cal_idx) : 16'h0000)) == `TCCR_CAL_ALL;

    // resolution staging: values only reach the gesture engine as a pair
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hres_up_q <= `TCCR_BYTE_RST;
            hres_lo_q <= `TCCR_BYTE_RST;
            vres_up_q <= `TCCR_BYTE_RST;
            vres_lo_q <= `TCCR_BYTE_RST;
            hres_wr_q <= 1'b0;
            vres_wr_q <= 1'b0;
            res_q     <= '{horiz: `TCCR_RES_RST, vert: `TCCR_RES_RST};
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `TCCR_HRES_UP)
                hres_up_q <= reg_wdata & `TCCR_RES_UP_MASK;
            if (reg_wr && reg_addr == `TCCR_HRES_LO)
                hres_lo_q <= reg_wdata;
            if (reg_wr && reg_addr == `TCCR_VRES_UP)
                vres_up_q <= reg_wdata & `TCCR_RES_UP_MASK;
            if (reg_wr && reg_addr == `TCCR_VRES_LO)
                vres_lo_q <= reg_wdata;
            if (res_commit) begin
                hres_wr_q <= 1'b0;
                vres_wr_q <= 1'b0;
            end else begin
                hres_wr_q <= hres_wr_q | wr_hres;
                vres_wr_q <= vres_wr_q | wr_vres;
            end
            // commit takes the byte being written in the same cycle
            if (res_commit) begin
                res_q.horiz <= {(reg_wr && reg_addr == `TCCR_HRES_UP) ? reg_wdata[5:0] : hres_up_q[5:0],
                                (reg_wr && reg_addr == `TCCR_HRES_LO) ? reg_wdata : hres_lo_q};
                res_q.vert  <= {(reg_wr && reg_addr == `TCCR_VRES_UP) ? reg_wdata[5:0] : vres_up_q[5:0],
                                (reg_wr && reg_addr == `TCCR_VRES_LO) ? reg_wdata : vres_lo_q};
            end
        end
    end

    // calibration store and completeness tracking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < `TCCR_CAL_BYTES; i++)
                cal_q[i] <= `TCCR_BYTE_RST;
        end else if (clk_en && wr_cal) begin
            cal_q[cal_idx] <= reg_wdata;
        end
    end

    // a resolution write in the completing cycle wins: device stays uncalibrated
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cal_seen_q <= 16'h0000;
            uncal_q    <= 1'b1;
        end else if (clk_en) begin
            if (wr_hres || wr_vres) begin
                cal_seen_q <= 16'h0000;
                uncal_q    <= 1'b1;
            end else if (cal_done) begin
                cal_seen_q <= 16'h0000;
                uncal_q    <= 1'b0;
            end else if (wr_cal) begin
                cal_seen_q <= cal_seen_q | (16'h0001 << cal_idx);
            end
        end
    end

    // plain configuration registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slide_q      <= `TCCR_BYTE_RST;
            cfg_q        <= `TCCR_BYTE_RST;
            trk_rate_q   <= `TCCR_BYTE_RST;
            resp_q       <= `TCCR_BYTE_RST;
            stuck_tout_q <= `TCCR_BYTE_RST;
            lp_sel_q     <= `TCCR_BYTE_RST;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `TCCR_SLIDE_STEPS: slide_q      <= reg_wdata;
                `TCCR_CAP_CFG:     cfg_q        <= reg_wdata & `TCCR_CFG_MASK;
                `TCCR_TRK_RATE:    trk_rate_q   <= reg_wdata;
                `TCCR_RESP_TIME:   resp_q       <= reg_wdata & `TCCR_RESP_MASK;
                `TCCR_STUCK_TOUT:  stuck_tout_q <= reg_wdata;
                `TCCR_LP_SEL:      lp_sel_q     <= reg_wdata & `TCCR_LP_SEL_MASK;
                default: ;
            endcase
        end
    end

    // read port; unmapped addresses return zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= `TCCR_BYTE_RST;
        end else if (clk_en) begin
            if (reg_rd) begin
                case (reg_addr)
                    `TCCR_HRES_UP:     rdata_q <= hres_up_q;
                    `TCCR_HRES_LO:     rdata_q <= hres_lo_q;
                    `TCCR_VRES_UP:     rdata_q <= vres_up_q;
                    `TCCR_VRES_LO:     rdata_q <= vres_lo_q;
                    `TCCR_SLIDE_STEPS: rdata_q <= slide_q;
                    `TCCR_CAP_CFG:     rdata_q <= cfg_q;
                    `TCCR_TRK_RATE:    rdata_q <= trk_rate_q;
                    `TCCR_RESP_TIME:   rdata_q <= resp_q;
                    `TCCR_STUCK_TOUT:  rdata_q <= stuck_tout_q;
                    `TCCR_LP_SEL:      rdata_q <= lp_sel_q;
                    `TCCR_STATUS2:     rdata_q <= 8'(uncal_q) << `TCCR_ST2_CAL_BIT;
                    default: begin
                        if (reg_addr >= `TCCR_CAL_BASE && reg_addr <= `TCCR_CAL_LAST)
                            rdata_q <= cal_q[cal_idx_rd];
                        else
                            rdata_q <= 8'h00;
                    end
                endcase
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // coordinate mapping: signed coefficients, unsigned samples, full-width sum
    logic signed [15:0] cx0, cx1, cx2, cy0, cy1, cy2;
    logic signed [34:0] x_sum, y_sum;
    assign cx0 = {cal_q[0],  cal_q[1]};
    assign cx1 = {cal_q[2],  cal_q[3]};
    assign cx2 = {cal_q[4],  cal_q[5]};
    assign cy0 = {cal_q[6],  cal_q[7]};
    assign cy1 = {cal_q[8],  cal_q[9]};
    assign cy2 = {cal_q[10], cal_q[11]};

    always_comb begin
        x_sum = 35'(cx0 * $signed({1'b0, raw_x})) + 35'(cx1 * $signed({1'b0, raw_y})) + 35'(cx2);
        y_sum = 35'(cy0 * $signed({1'b0, raw_x})) + 35'(cy1 * $signed({1'b0, raw_y})) + 35'(cy2);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            coord_q       <= '{x: 16'h0000, y: 16'h0000};
            coord_valid_q <= 1'b0;
        end else if (clk_en) begin
            coord_valid_q <= sample_valid;
            if (sample_valid) begin
                coord_q.x <= x_sum[15:0];
                coord_q.y <= y_sum[15:0];
            end
        end
    end

    // capacitive control: low-power wake stops run-mode scanning entirely
    assign scan_tick = cap_sample_tick && !lpw_en;
    assign trk_hit   = scan_tick && trk_en && trk_rate_q != 8'h00
                       && (9'(trk_cnt_q) + 9'h001 >= 9'(trk_rate_q));
    // out-of-range response values clamp to the nearest legal count
    assign deb_n = (resp_q[5:0] == 6'h00) ? `TCCR_DEB_MIN :
                   (resp_q[5:0] > `TCCR_DEB_MAX) ? `TCCR_DEB_MAX : resp_q[5:0];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trk_cnt_q <= 8'h00;
        end else if (clk_en) begin
            if (!trk_en || trk_rate_q == 8'h00 || trk_hit)
                trk_cnt_q <= 8'h00;
            else if (scan_tick)
                trk_cnt_q <= trk_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_scan_q <= 1'b1;
            lp_mask_q  <= 4'h0;
        end else if (clk_en) begin
            run_scan_q <= !lpw_en;
            lp_mask_q  <= lpw_en ? (4'h1 << lp_sel_q[1:0]) : 4'h0;
        end
    end

    logic [3:0] touched_q, rebase_q;
    genvar g;
    generate
        for (g = 0; g < `TCCR_ELECTRODES; g++) begin : g_elec
            logic [5:0] deb_cnt_q;
            logic [7:0] stk_cnt_q;
            logic       stk_hit;
            assign stk_hit = scan_tick && stk_en && stuck_tout_q != 8'h00 && touched_q[g]
                             && (9'(stk_cnt_q) + 9'h001 >= 9'(stuck_tout_q));

            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    deb_cnt_q    <= 6'h00;
                    stk_cnt_q    <= 8'h00;
                    touched_q[g] <= 1'b0;
                    rebase_q[g]  <= 1'b0;
                end else if (clk_en) begin
                    rebase_q[g] <= stk_hit || trk_hit;
                    if (stk_hit) begin
                        // fresh baseline releases the electrode
                        touched_q[g] <= 1'b0;
                        deb_cnt_q    <= 6'h00;
                        stk_cnt_q    <= 8'h00;
                    end else if (scan_tick) begin
                        if (elec_raw_touch[g] != touched_q[g]) begin
                            if (deb_cnt_q + 6'h01 >= deb_n) begin
                                touched_q[g] <= elec_raw_touch[g];
                                deb_cnt_q    <= 6'h00;
                            end else begin
                                deb_cnt_q <= deb_cnt_q + 6'h01;
                            end
                        end else begin
                            deb_cnt_q <= 6'h00;
                        end
                        if (touched_q[g] && stk_en && stuck_tout_q != 8'h00)
                            stk_cnt_q <= stk_cnt_q + 8'h01;
                        else
                            stk_cnt_q <= 8'h00;
                    end
                end
            end
        end
    endgenerate

    assign reg_rdata          = rdata_q;
    assign coord              = coord_q;
    assign coord_valid        = coord_valid_q;
    assign resolution         = res_q;
    assign slide_step_count   = slide_q;
    assign two_touch_const_x  = {cal_q[12], cal_q[13]};
    assign two_touch_const_y  = {cal_q[14], cal_q[15]};
    assign uncalibrated       = uncal_q;
    assign elec_touched       = touched_q;
    assign baseline_update    = rebase_q;
    assign run_scan_enable    = run_scan_q;
    assign shutdown_scan_mask = lp_mask_q;

    // checks
    res_lone_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr_hres && !vres_wr_q && !hres_wr_q |=> $stable(res_q))
        else $error("resolution applied before both axes written");

    res_pair_commit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && res_commit |=> !hres_wr_q && !vres_wr_q)
        else $error("pending flags not cleared at commit");

    res_reserved_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hres_up_q[7:6] == 2'b00 && vres_up_q[7:6] == 2'b00)
        else $error("reserved resolution bits set");

    cal_invalidate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && (wr_hres || wr_vres) |=> uncal_q && cal_seen_q == 16'h0000)
        else $error("resolution write kept calibration");

    cal_complete_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && $fell(uncal_q) |-> $past(wr_cal) && $past(cal_done))
        else $error("calibration completed without all bytes");

    coord_calc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && sample_valid |=> coord_valid_q && coord_q.x == $past(x_sum[15:0]))
        else $error("x coordinate not taken from sample");

    coord_y_calc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && sample_valid |=> coord_q.y == $past(y_sum[15:0]))
        else $error("y coordinate not taken from sample");

    lp_no_scan_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && lpw_en |=> !run_scan_q ##0 $stable(touched_q) [*1])
        else $error("electrodes scanned with low-power wake set");

    lp_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && lpw_en |=> lp_mask_q == (4'h1 << $past(lp_sel_q[1:0])))
        else $error("wrong shutdown electrode selected");

    lp_mask_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && !lpw_en |=> lp_mask_q == 4'h0)
        else $error("shutdown electrode selected without low-power wake");

    trk_disabled_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && trk_rate_q == 8'h00 && !stk_en |=> rebase_q == 4'h0)
        else $error("baseline update with tracker disabled");

    debounce_min_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        deb_n >= `TCCR_DEB_MIN && deb_n <= `TCCR_DEB_MAX)
        else $error("debounce count out of range");

endmodule : tccr_regs
